// ---- logic/program_counter_monitor.sv ----
// program counter monitor with peak tracking and block interrupt counter
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - 16-bit frame threshold register, resets to zero
// - count frame starts; on match interrupt, restart
// - block interrupts only while enable bit set
// - pc upper byte in bits 7..0
// - pc lower sixteen bits, read only
// - clear bit set: pc zero and frozen
// - clear bit low: pc follows execution
// - set then clear zeroes all-time peak
// - per-frame peak of last frame or block
// - clear control also zeroes per-frame peak
// - all-time peak raised by any larger peak
// - all peak and pc fields reset zero
module program_counter_monitor
  import pc_mon_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // register bus
  input  wire pc_mon_pkg::wb_req_s  wb_req,
  output var  pc_mon_pkg::wb_rsp_s  wb_rsp,
  // program sequencer
  input  wire pc_mon_pkg::seq_in_s  seq_in,
  output logic                      pc_clear,
  output logic                      block_irq,
  // interrupt to the host
  output logic                      irq
);
  import pc_mon_pkg::*;

  // all state of the block except the two reset synchroniser flops
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic             clr;
    logic             en;
    logic [REG_W-1:0] thr;
    logic [REG_W-1:0] fcnt;
    logic [PC_W-1:0]  run_peak;
    logic [PC_W-1:0]  frame_peak;
    logic [PC_W-1:0]  alltime;
    logic [EV_N-1:0]  sts;
    logic [EV_N-1:0]  mask;
    logic             birq;
    logic             ack;
    logic [REG_W-1:0] rdat;
  } state_s;

  localparam state_s ST_RST = '{
    pc: RST_PC, clr: 1'b0, en: 1'b0, thr: RST_THRESHOLD, fcnt: 16'h0000,
    run_peak: RST_PC, frame_peak: RST_PC, alltime: RST_PC, sts: 2'h0,
    mask: 2'h0, birq: 1'b0, ack: 1'b0, rdat: 16'h0000};

  state_s           st_r;
  state_s           st_nxt;
  logic [1:0]       rst_sync_r;
  logic             rst_l;
  logic             req;
  logic             wr_ok;
  logic             rd_ok;
  logic [15:0]      idx;
  logic [16:0]      fcnt_inc;
  logic             hit;
  logic             bnd;
  logic [PC_W-1:0]  peak_now;
  logic [REG_W-1:0] wval;
  logic [REG_W-1:0] rmux;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; async assert, clocked release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_l = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // bus decode; writes and read-clears commit on the ack edge only
  assign req   = wb_req.cyc & wb_req.stb;
  assign idx   = wb_req.adr[ADR_W-1:2];
  assign wr_ok = req & wb_req.we & st_r.ack;
  assign rd_ok = req & ~wb_req.we & st_r.ack;
  // byte lanes: sel[0] low byte, sel[1] high byte; upper lanes unused
  assign wval  = {wb_req.sel[1] ? wb_req.dat[15:8] : 8'h00,
                  wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00};

  // frame counting and boundary of a frame or block
  assign fcnt_inc = {1'b0, st_r.fcnt} + 17'h00001;
  assign hit      = seq_in.frame_start & (fcnt_inc == {1'b0, st_r.thr});
  // with block interrupts off each frame is its own block
  assign bnd      = seq_in.frame_start & (~st_r.en | hit);
  // peak so far including the pc seen this cycle
  assign peak_now = (st_r.pc > st_r.run_peak) ? st_r.pc : st_r.run_peak;

  // read data mux; reserved upper bits read as zero
  always_comb begin
    rmux = 16'h0000;
    unique case (idx)
      IDX_PC_HIGH:    rmux = {8'h00, st_r.pc[23:16]};
      IDX_PC_LOW:     rmux = st_r.pc[15:0];
      IDX_PC_CLEAR:   rmux = {15'h0000, st_r.clr};
      IDX_FPEAK_HIGH: rmux = {8'h00, st_r.frame_peak[23:16]};
      IDX_FPEAK_LOW:  rmux = st_r.frame_peak[15:0];
      IDX_APEAK_HIGH: rmux = {8'h00, st_r.alltime[23:16]};
      IDX_APEAK_LOW:  rmux = st_r.alltime[15:0];
      IDX_IRQ_EN:     rmux = {15'h0000, st_r.en};
      IDX_THRESHOLD:  rmux = st_r.thr;
      IDX_IRQ_STATUS: rmux = {14'h0000, st_r.sts};
      IDX_IRQ_MASK:   rmux = {14'h0000, st_r.mask};
      default:        rmux = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt      = st_r;
    st_nxt.birq = 1'b0;
    // single-cycle ack, dropped the cycle after it is given
    st_nxt.ack  = req & ~st_r.ack;
    if (req & ~st_r.ack) begin
      st_nxt.rdat = rmux;
    end
    // register writes
    if (wr_ok) begin
      unique case (idx)
        IDX_PC_CLEAR:  st_nxt.clr  = wval[BIT_CLEAR];
        IDX_IRQ_EN:    st_nxt.en   = wval[BIT_ENABLE];
        IDX_THRESHOLD: st_nxt.thr  = wval;
        IDX_IRQ_MASK:  st_nxt.mask = wval[EV_N-1:0];
        default:       st_nxt.thr  = st_r.thr;
      endcase
    end
    // status read clears only the bits it returned, so an event landing between
    // the data capture and the ack edge is kept; events below still win
    if (rd_ok && idx == IDX_IRQ_STATUS) begin
      st_nxt.sts = st_r.sts & ~st_r.rdat[EV_N-1:0];
    end
    // frame counter restarts on the matching frame
    if (seq_in.frame_start) begin
      st_nxt.fcnt = hit ? 16'h0000 : fcnt_inc[15:0];
    end
    if (hit && st_r.en) begin
      st_nxt.birq = 1'b1;
      st_nxt.sts[EV_BLOCK] = 1'b1;
    end
    // pc follows the sequencer unless the clear bit holds it at zero
    st_nxt.pc = st_nxt.clr ? RST_PC : seq_in.pc;
    // peak tracking
    if (bnd) begin
      st_nxt.frame_peak = peak_now;
      st_nxt.run_peak   = RST_PC;
      if (peak_now > st_r.alltime) begin
        st_nxt.alltime = peak_now;
        st_nxt.sts[EV_NEWPEAK] = 1'b1;
      end
    end else begin
      st_nxt.run_peak = peak_now;
    end
    // clear control empties the frame records while set
    if (st_nxt.clr) begin
      st_nxt.run_peak   = RST_PC;
      st_nxt.frame_peak = RST_PC;
    end
    // falling clear bit ends the set-then-clear sequence
    if (st_r.clr && !st_nxt.clr) begin
      st_nxt.alltime = RST_PC;
    end
  end

  // state register; everything resets to zero
  always_ff @(posedge clk or negedge rst_l) begin
    if (!rst_l) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_rsp.ack = st_r.ack;
  assign wb_rsp.dat = {16'h0000, st_r.rdat};
  assign pc_clear   = st_r.clr;
  assign block_irq  = st_r.birq;
  // level interrupt while any unmasked sticky bit is set
  assign irq        = |(st_r.sts & st_r.mask);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_l);
  // state still shows reset values at the first enabled edge, so checks that
  // look back across the release are guarded by the synchronised reset's past

  a_thr_write: assert property (
    wr_ok && idx == IDX_THRESHOLD && wb_req.sel[1:0] == 2'b11
    |=> st_r.thr == $past(wb_req.dat[15:0]))
    else $error("threshold write lost");

  a_block_count: assert property (
    seq_in.frame_start && st_r.en && st_r.thr != 16'h0000
    && st_r.fcnt == st_r.thr - 16'h0001
    |=> block_irq && st_r.fcnt == 16'h0000)
    else $error("block interrupt missing at threshold");

  a_irq_enable: assert property (
    block_irq |-> $past(st_r.en) && $past(seq_in.frame_start))
    else $error("block interrupt without enable");

  a_high_reserved: assert property (
    wb_rsp.ack && $past(idx) == IDX_PC_HIGH
    |-> wb_rsp.dat[15:8] == 8'h00 && wb_rsp.dat[7:0] == $past(st_r.pc[23:16]))
    else $error("pc upper byte read wrong");

  a_pc_frozen: assert property (
    st_r.clr ##1 st_r.clr |-> st_r.pc == RST_PC && pc_clear)
    else $error("pc not held at zero");

  a_pc_follow: assert property (
    $past(rst_l) && !st_r.clr |-> st_r.pc == $past(seq_in.pc))
    else $error("pc not following sequencer");

  a_alltime_clear: assert property (
    $fell(st_r.clr) |-> st_r.alltime == RST_PC)
    else $error("all-time peak not cleared");

  a_frame_clear: assert property (
    st_r.clr |-> st_r.frame_peak == RST_PC && st_r.run_peak == RST_PC)
    else $error("frame peak not cleared");

  a_peak_order: assert property (
    !st_r.clr && !$fell(st_r.clr) |-> st_r.alltime >= st_r.frame_peak)
    else $error("all-time peak below frame peak");

  a_frame_xfer: assert property (
    bnd && !st_nxt.clr |=> st_r.frame_peak == $past(peak_now)
    && st_r.run_peak == RST_PC)
    else $error("frame peak not transferred");

  a_irq_level: assert property (
    irq && !wr_ok && !(rd_ok && idx == IDX_IRQ_STATUS) |=> irq)
    else $error("interrupt dropped without a status read");

  // an event the read did not return must survive the read-clear
  a_rdclr_keep: assert property (
    rd_ok && idx == IDX_IRQ_STATUS && st_r.sts[EV_BLOCK] && !st_r.rdat[EV_BLOCK]
    |=> st_r.sts[EV_BLOCK])
    else $error("unread status event lost");

  // bus handshake and read data
  a_ack_answer: assert property (
    req && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered next cycle");

  a_ack_pulse: assert property (
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held more than one cycle");

  a_write_lands: assert property (
    req && wb_req.we && !st_r.ack |=> $stable(st_r.thr))
    else $error("write took effect before ack");

  a_low_read: assert property (
    wb_rsp.ack && $past(idx) == IDX_PC_LOW
    |-> wb_rsp.dat[15:0] == $past(st_r.pc[15:0]))
    else $error("pc lower half read wrong");

  a_fpeak_read: assert property (
    wb_rsp.ack && $past(idx) == IDX_FPEAK_HIGH
    |-> wb_rsp.dat[15:0] == {8'h00, $past(st_r.frame_peak[23:16])})
    else $error("frame peak upper byte read wrong");

  a_apeak_read: assert property (
    wb_rsp.ack && $past(idx) == IDX_APEAK_LOW
    |-> wb_rsp.dat[15:0] == $past(st_r.alltime[15:0]))
    else $error("all-time peak lower half read wrong");

  a_unmapped_read: assert property (
    wb_rsp.ack && $past(idx) > IDX_IRQ_MASK |-> wb_rsp.dat == 32'h00000000)
    else $error("unmapped read not zero");

  // records and clear control
  a_clr_write: assert property (
    wr_ok && idx == IDX_PC_CLEAR && wval[BIT_CLEAR]
    |=> pc_clear && st_r.pc == RST_PC)
    else $error("clear write did not freeze pc");

  a_run_peak: assert property (
    !bnd && !st_nxt.clr
    |=> st_r.run_peak == $past(peak_now))
    else $error("running peak not tracking");

  a_fpeak_hold: assert property (
    !bnd && !st_nxt.clr |=> $stable(st_r.frame_peak))
    else $error("frame peak moved inside a frame");

  a_alltime_hold: assert property (
    !bnd && !(st_r.clr && !st_nxt.clr)
    |=> $stable(st_r.alltime))
    else $error("all-time peak moved without a boundary");

  a_alltime_rise: assert property (
    bnd && !(st_r.clr && !st_nxt.clr) && peak_now > st_r.alltime
    |=> st_r.alltime == $past(peak_now) && st_r.sts[EV_NEWPEAK])
    else $error("larger peak not recorded");

  // frame counter and block events
  a_thr_zero: assert property (
    st_r.thr == 16'h0000 |=> !block_irq)
    else $error("block interrupt with zero threshold");

  a_count_step: assert property (
    seq_in.frame_start && !hit
    |=> st_r.fcnt == $past(st_r.fcnt) + 16'h0001)
    else $error("frame counter did not step");

  a_count_idle: assert property (
    !seq_in.frame_start |=> $stable(st_r.fcnt))
    else $error("frame counter moved without a frame");

  a_block_event: assert property (
    hit && st_r.en |=> block_irq && st_r.sts[EV_BLOCK])
    else $error("enabled block not signalled");

  a_en_gate: assert property (
    !st_r.en |=> !block_irq)
    else $error("block interrupt while disabled");

  c_block_irq: cover property (block_irq ##[1:50] block_irq);
  c_new_peak: cover property (bnd ##1 st_r.sts[EV_NEWPEAK]);
  c_clear_seq: cover property ($rose(st_r.clr) ##[1:20] $fell(st_r.clr));
  c_status_rd: cover property (irq ##[1:20] rd_ok && idx == IDX_IRQ_STATUS);
  c_thr_write: cover property (wr_ok && idx == IDX_THRESHOLD);

endmodule // program_counter_monitor

`default_nettype wire

// ---- logic/pc_mon_pkg.sv ----
// constants and carriers for the program counter monitor
package pc_mon_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PC_HIGH    = 16'hf460;
  localparam logic [15:0] IDX_PC_LOW     = 16'hf461;
  localparam logic [15:0] IDX_PC_CLEAR   = 16'hf462;
  localparam logic [15:0] IDX_FPEAK_HIGH = 16'hf463;
  localparam logic [15:0] IDX_FPEAK_LOW  = 16'hf464;
  localparam logic [15:0] IDX_APEAK_HIGH = 16'hf465;
  localparam logic [15:0] IDX_APEAK_LOW  = 16'hf466;
  localparam logic [15:0] IDX_IRQ_EN     = 16'hf450;
  localparam logic [15:0] IDX_THRESHOLD  = 16'hf451;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hf470;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hf471;
  // widths and field positions
  localparam int ADR_W       = 18;
  localparam int PC_W        = 24;
  localparam int REG_W       = 16;
  localparam int BIT_CLEAR   = 0;
  localparam int BIT_ENABLE  = 0;
  localparam int EV_BLOCK    = 0;
  localparam int EV_NEWPEAK  = 1;
  localparam int EV_N        = 2;
  // reset values
  localparam logic [15:0] RST_THRESHOLD = 16'h0000;
  localparam logic [23:0] RST_PC        = 24'h000000;

  // classic wishbone request from the master
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } wb_req_s;

  // wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // what the program sequencer supplies each cycle
  typedef struct packed {
    logic            frame_start;
    logic [PC_W-1:0] pc;
  } seq_in_s;
endpackage

// ---- verif/seq_model.sv ----
// behavioural program sequencer that feeds pc values and frame starts
`timescale 1ns/1ns
`default_nettype none
module seq_model
  import pc_mon_pkg::*;
(
  // commands from the bench
  input  wire logic [23:0]         pc_set,
  input  wire logic                fs_go,
  // monitor side
  input  wire logic                pc_clear,
  output var  pc_mon_pkg::seq_in_s seq
);
  // a frozen sequencer parks its pc at zero until the monitor releases it
  always_comb begin
    seq.frame_start = fs_go;
    seq.pc          = pc_clear ? 24'h000000 : pc_set;
  end
endmodule // seq_model
`default_nettype wire

// ---- verif/program_counter_monitor_tb.sv ----
// self-checking bench for the program counter monitor
`timescale 1ns/1ns
`default_nettype none
module program_counter_monitor_tb;
  import pc_mon_pkg::*;
  logic        clk;
  logic        rst_n;
  wb_req_s     req;
  wb_rsp_s     rsp;
  seq_in_s     seq;
  logic        pc_clear;
  logic        block_irq;
  logic        irq;
  logic [23:0] pc_set;
  logic        fs_go;
  logic [15:0] rd;
  int          err_total;
  int          total_checks;
  int          blk_n;

  program_counter_monitor uut (.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
    .seq_in(seq), .pc_clear(pc_clear), .block_irq(block_irq), .irq(irq));
  seq_model seq_m (.pc_set(pc_set), .fs_go(fs_go), .pc_clear(pc_clear), .seq(seq));

  // clock and block pulse counter; counting cycles high also proves a one-cycle pulse
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (block_irq === 1'b1) blk_n++;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic wishbone single cycle; hold until ack is sampled, then idle a cycle
  // no cycle count is assumed here: only the watchdog ends a wait
  task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h3, dat: {16'h0, wd}};
    do begin
      @(posedge clk);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat[15:0];
    req <= '0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    chk(rd, exp);
  endtask

  task automatic frame(input int n);
    repeat (n) begin
      @(posedge clk) fs_go <= 1'b1;
      @(posedge clk) fs_go <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic set_pc(input logic [23:0] v);
    @(posedge clk) pc_set <= v;
    repeat (3) @(posedge clk);
  endtask

  // watchdog well beyond the under two hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    clk = 0; rst_n = 0; req = '0; pc_set = '0; fs_go = 0;
    err_total = 0; total_checks = 0; blk_n = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values of every record and the threshold
    for (int i = 0; i < 7; i++) rchk(IDX_PC_HIGH + 16'(i), 16'h0000);
    rchk(IDX_THRESHOLD, RST_THRESHOLD);
    bus(1'b1, IDX_THRESHOLD, 16'ha5c3);
    rchk(IDX_THRESHOLD, 16'ha5c3);
    bus(1'b1, IDX_PC_LOW, 16'h1234);
    rchk(IDX_PC_LOW, 16'h0000);
    rchk(16'hf4ff, 16'h0000);
    // live pc split across two registers
    set_pc(24'h123456);
    rchk(IDX_PC_HIGH, 16'h0012);
    rchk(IDX_PC_LOW, 16'h3456);
    // with blocks off every frame start closes a peak window
    set_pc(24'h0abcde);
    set_pc(24'h000100);
    frame(1);
    // the window open since reset still holds the earlier, higher pc
    rchk(IDX_FPEAK_HIGH, 16'h0012);
    rchk(IDX_FPEAK_LOW, 16'h3456);
    rchk(IDX_APEAK_LOW, 16'h3456);
    chk(16'(irq), 16'h0000);
    set_pc(24'h000050);
    frame(1);
    rchk(IDX_FPEAK_LOW, 16'h0100);
    rchk(IDX_APEAK_HIGH, 16'h0012);
    // clear control freezes pc and wipes the records
    bus(1'b1, IDX_PC_CLEAR, 16'h0001);
    @(posedge clk);
    chk(16'(pc_clear), 16'h0001);
    rchk(IDX_PC_LOW, 16'h0000);
    rchk(IDX_FPEAK_LOW, 16'h0000);
    bus(1'b1, IDX_PC_CLEAR, 16'h0000);
    rchk(IDX_APEAK_HIGH, 16'h0000);
    rchk(IDX_APEAK_LOW, 16'h0000);
    rchk(IDX_PC_LOW, 16'h0050);
    // block of three frames, then disabled blocks stay silent
    bus(1'b1, IDX_THRESHOLD, 16'h0003);
    bus(1'b1, IDX_IRQ_EN, 16'h0001);
    bus(1'b1, IDX_IRQ_MASK, 16'h0001);
    bus(1'b0, IDX_IRQ_STATUS, 16'h0);
    blk_n = 0;
    // two frames counted while blocks were off complete the first block
    frame(1);
    chk(16'(blk_n), 16'h0001);
    frame(2);
    chk(16'(blk_n), 16'h0001);
    frame(1);
    chk(16'(blk_n), 16'h0002);
    chk(16'(irq), 16'h0001);
    rchk(IDX_IRQ_STATUS, 16'h0003);
    @(posedge clk);
    chk(16'(irq), 16'h0000);
    bus(1'b1, IDX_IRQ_EN, 16'h0000);
    frame(3);
    chk(16'(blk_n), 16'h0002);
    close_out();
  end
endmodule // program_counter_monitor_tb
`default_nettype wire
